// [rtl/arc_regs.sv]
// arc_regs: result, compare, trigger/compare control, calibration control,
// offset, gain and calibration-value registers of the converter.
// assumes a synchronous 8-bit register port and an analog core that
// reports each finished conversion and calibration with a one-cycle pulse.
// Function
// - high-byte read locks result pair until low byte read.
// - result finishing while locked is dropped.
// - 8-bit resolution never locks; every result that passes compare lands.
// - result unsigned right justified, unused upper bits zero.
// - low byte holds bits 7:0, high byte the upper bits.
// - compare high supplies four or two upper bits, unused in 8-bit.
// - compare low bits compared against result bits 7:0.
// - active bit set on conversion start, cleared on finish or abort.
// - trigger select picks software write or hardware trigger input.
// - compare enable turns automatic compare on or off.
// - compare direction: 0 less than, 1 greater or equal.
// - calibration bit starts calibration, stays set, self-clears on finish.
// - starting calibration aborts a running conversion.
// - calibration fails with hardware trigger selected, register write or stop.
// - writing one clears calibration-failed flag, zero leaves it.
// - continuous bit repeats conversions after a trigger.
// - left-justified signed offset subtracted before storing result.
// - corrected result saturates to resolution limits.
// - calibration finish loads seven plus-side values.
// - calibration finish loads seven minus-side values.
// - resolution 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// - storing a result pulses the conversion-complete flag set.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module arc_regs
	import arc_pkg::*;
#(
	parameter int AW = 8
) (
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          arst_n_i,
	// register port
	input  wire logic [AW-1:0] reg_addr_i,
	input  wire logic [7:0]    reg_wdata_i,
	input  wire logic          reg_wr_i,
	input  wire logic          reg_rd_i,
	output logic      [7:0]    reg_rdata_o,
	// converter side
	input  wire arc_res_t      mode_i,
	input  wire logic          sc1_wr_i,
	input  wire logic          hw_trig_i,
	input  wire logic          stop_i,
	input  wire arc_conv_t     conv_i,
	input  wire arc_cal_t      cal_i,
	// controls and events
	output logic               conv_start_o,
	output logic               conv_abort_o,
	output logic               cal_start_o,
	output logic               conv_complete_o,
	output logic      [15:0]   plus_gain_o,
	output logic      [15:0]   minus_gain_o
);
	// register state
	logic [11:0] result;
	logic        lock;
	logic [7:0]  cv_hi, cv_lo;
	logic        active, trg_sel, cmp_en, cmp_ge;
	logic        cal_busy, calibration_failed_flag, cont;
	logic [15:0] ofs_val, pg_val, mg_val;
	logic [NUM_CAL-1:0][9:0] calp, calm;

	// address decode
	wire wr_hit_tc  = reg_wr_i && reg_addr_i == AW'(OFS_TRGCMP);
	wire wr_hit_cc  = reg_wr_i && reg_addr_i == AW'(OFS_CALCONT);
	wire rd_hit_rh  = reg_rd_i && reg_addr_i == AW'(OFS_RES_HI);
	wire rd_hit_rl  = reg_rd_i && reg_addr_i == AW'(OFS_RES_LO);
	wire is_8bit    = mode_i == RES_8;

	// calibration start; a write that sets the bit while idle
	wire cal_go     = wr_hit_cc && reg_wdata_i[BIT_CAL] && !cal_busy;
	wire cal_end    = cal_busy && cal_i.done;
	// any other write or outside write during calibration spoils it
	wire cal_spoil  = cal_busy && (trg_sel || stop_i || sc1_wr_i ||
		(reg_wr_i && !cal_go));
	wire calibration_failed_flag_clr   = wr_hit_cc && reg_wdata_i[BIT_CALIBRATION_FAILED_FLAG];

	// conversion starts: software write or hardware trigger, then repeats
	wire sw_start   = sc1_wr_i && !trg_sel;
	wire hw_start   = hw_trig_i && trg_sel;
	wire conv_end   = active && conv_i.done;
	wire restart    = conv_end && cont;
	wire start      = (sw_start || hw_start || restart) && !cal_busy && !cal_go;
	wire abort      = cal_go && active;

	// offset: left justified, so shift down to the result's lsb weight
	wire [3:0] ofs_sh = is_8bit ? 4'd8 : (mode_i == RES_10 ? 4'd6 : 4'd4);
	wire signed [16:0] ofs_al = 17'(signed'(ofs_val) >>> ofs_sh);
	wire signed [16:0] diff = signed'({5'b0_0000, conv_i.raw}) - ofs_al;
	wire [11:0] res_max = is_8bit ? 12'h00FF :
		(mode_i == RES_10 ? 12'h03FF : 12'h0FFF);
	// saturate to 0..max of the current resolution
	wire [11:0] corr = diff < 0 ? 12'h0000 :
		(diff > signed'({5'b0_0000, res_max}) ? res_max : diff[11:0]);

	// compare value masked per resolution; high byte unused in 8-bit
	wire [11:0] cv_full = is_8bit ? {4'h0, cv_lo} :
		(mode_i == RES_10 ? {2'b00, cv_hi[1:0], cv_lo} : {cv_hi[3:0], cv_lo});
	wire cmp_hit = cmp_ge ? (corr >= cv_full) : (corr < cv_full);
	wire cmp_ok  = !cmp_en || cmp_hit;
	// locked pair drops the result; 8-bit ignores the lock
	wire store   = conv_end && cmp_ok && !(lock && !is_8bit);

	// result pair and read interlock
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result <= 12'h000;
			lock   <= 1'b0;
		end else begin
			if (store)
				result <= corr & res_max;
			if (rd_hit_rl)
				lock <= 1'b0;
			else if (rd_hit_rh && !is_8bit)
				lock <= 1'b1;
		end
	end

	// conversion active and trigger/compare control
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			active  <= 1'b0;
			trg_sel <= 1'b0;
			cmp_en  <= 1'b0;
			cmp_ge  <= 1'b0;
		end else begin
			if (start)
				active <= 1'b1;
			else if (conv_end || abort)
				active <= 1'b0;
			if (wr_hit_tc) begin
				trg_sel <= reg_wdata_i[BIT_TRGSEL];
				cmp_en  <= reg_wdata_i[BIT_CMPEN];
				cmp_ge  <= reg_wdata_i[BIT_CMPGE];
			end
		end
	end

	// calibration control; the fail flag set wins over its clear
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cal_busy <= 1'b0;
			calibration_failed_flag     <= 1'b0;
			cont     <= 1'b0;
		end else begin
			if (cal_go)
				cal_busy <= 1'b1;
			else if (cal_end)
				cal_busy <= 1'b0;
			if (cal_spoil)
				calibration_failed_flag <= 1'b1;
			else if (calibration_failed_flag_clr)
				calibration_failed_flag <= 1'b0;
			if (wr_hit_cc)
				cont <= reg_wdata_i[BIT_CONT];
		end
	end

	// plain byte registers: compare value, offset and gains
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cv_hi   <= RST_BYTE;
			cv_lo   <= RST_BYTE;
			ofs_val <= {RST_BYTE, RST_BYTE};
			pg_val  <= RST_GAIN;
			mg_val  <= RST_GAIN;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				AW'(OFS_CV_HI):   cv_hi         <= reg_wdata_i;
				AW'(OFS_CV_LO):   cv_lo         <= reg_wdata_i;
				AW'(OFS_OFSC_HI): ofs_val[15:8] <= reg_wdata_i;
				AW'(OFS_OFSC_LO): ofs_val[7:0]  <= reg_wdata_i;
				AW'(OFS_PG_HI):   pg_val[15:8]  <= reg_wdata_i;
				AW'(OFS_PG_LO):   pg_val[7:0]   <= reg_wdata_i;
				AW'(OFS_MG_HI):   mg_val[15:8]  <= reg_wdata_i;
				AW'(OFS_MG_LO):   mg_val[7:0]   <= reg_wdata_i;
				default:          ;
			endcase
		end
	end

	// calibration values: widths 6,7,8,9,10,6,6; hardware load on finish,
	// software may still overwrite each, loading the low byte and clearing bits 9:8
	localparam logic [6:0][3:0] CAL_W = {4'd6, 4'd6, 4'd10, 4'd9, 4'd8, 4'd7, 4'd6};
	genvar g;
	generate
		for (g = 0; g < NUM_CAL; g++) begin : g_cal
			wire [9:0] msk = 10'((11'd1 << CAL_W[g]) - 11'd1);
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					calp[g] <= 10'h000;
					calm[g] <= 10'h000;
				end else if (cal_end) begin
					calp[g] <= cal_i.plus[g] & msk;
					calm[g] <= cal_i.minus[g] & msk;
				end else if (reg_wr_i) begin
					if (reg_addr_i == AW'(OFS_CALP0 + 8'(g)))
						calp[g] <= {2'b00, reg_wdata_i} & msk;
					if (reg_addr_i == AW'(OFS_CALM0 + 8'(g)))
						calm[g] <= {2'b00, reg_wdata_i} & msk;
				end
			end
		end
	endgenerate

	// read mux; wide calibration values show only their low byte
	wire [AW-1:0] cal_idx_p = reg_addr_i - AW'(OFS_CALP0);
	wire [AW-1:0] cal_idx_m = reg_addr_i - AW'(OFS_CALM0);
	wire in_calp = reg_addr_i >= AW'(OFS_CALP0) && reg_addr_i < AW'(OFS_CALM0);
	wire in_calm = reg_addr_i >= AW'(OFS_CALM0) &&
		reg_addr_i < AW'(OFS_CALM0 + 8'(NUM_CAL));
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr_i)
			AW'(OFS_RES_HI):   rd_mux = {4'h0, result[11:8]};
			AW'(OFS_RES_LO):   rd_mux = result[7:0];
			AW'(OFS_CV_HI):    rd_mux = cv_hi;
			AW'(OFS_CV_LO):    rd_mux = cv_lo;
			AW'(OFS_TRGCMP):   rd_mux = {active, trg_sel, cmp_en, cmp_ge, 4'h0};
			AW'(OFS_CALCONT):  rd_mux = {cal_busy, calibration_failed_flag, 2'b00, cont, 3'b000};
			AW'(OFS_OFSC_HI):  rd_mux = ofs_val[15:8];
			AW'(OFS_OFSC_LO):  rd_mux = ofs_val[7:0];
			AW'(OFS_PG_HI):    rd_mux = pg_val[15:8];
			AW'(OFS_PG_LO):    rd_mux = pg_val[7:0];
			AW'(OFS_MG_HI):    rd_mux = mg_val[15:8];
			AW'(OFS_MG_LO):    rd_mux = mg_val[7:0];
			default: begin
				if (in_calp)
					rd_mux = calp[cal_idx_p[2:0]][7:0];
				else if (in_calm)
					rd_mux = calm[cal_idx_m[2:0]][7:0];
			end
		endcase
	end

	// registered read data and event pulses
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o     <= 8'h00;
			conv_complete_o <= 1'b0;
		end else begin
			reg_rdata_o     <= reg_rd_i ? rd_mux : 8'h00;
			conv_complete_o <= store;
		end
	end

	// start, abort and calibration pulses go straight to the core
	assign conv_start_o = start;
	assign conv_abort_o = abort;
	assign cal_start_o  = cal_go;
	assign plus_gain_o  = pg_val;
	assign minus_gain_o = mg_val;

	// checks
	property p_rh_lock;
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_hit_rh && !is_8bit |=> lock;
	endproperty
	a_rh_lock: assert property (p_rh_lock) else $error("high read did not lock");

	property p_lock_drop;
		@(posedge mclk_i) disable iff (!arst_n_i)
		lock && !is_8bit && conv_end |=> $stable(result) && !conv_complete_o;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("locked result overwritten");

	property p_8bit_free;
		@(posedge mclk_i) disable iff (!arst_n_i)
		is_8bit && conv_end && !cmp_en |=> conv_complete_o && result == $past(corr);
	endproperty
	a_8bit_free: assert property (p_8bit_free) else $error("8-bit result not stored");

	property p_upper_zero;
		@(posedge mclk_i) disable iff (!arst_n_i)
		store && is_8bit |=> result[11:8] == 4'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("8-bit upper bits set");

	property p_active;
		@(posedge mclk_i) disable iff (!arst_n_i)
		start |=> active;
	endproperty
	a_active: assert property (p_active) else $error("active not set on start");

	property p_cal_abort;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cal_go && active |=> !active && cal_busy ##1 !conv_start_o;
	endproperty
	a_cal_abort: assert property (p_cal_abort) else $error("calibration did not abort");

	property p_cal_stop;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cal_busy && stop_i |=> calibration_failed_flag;
	endproperty
	a_cal_stop: assert property (p_cal_stop) else $error("stop did not fail calibration");

	property p_calibration_failed_flag_w1c;
		@(posedge mclk_i) disable iff (!arst_n_i)
		calibration_failed_flag && calibration_failed_flag_clr && !cal_spoil |=> !calibration_failed_flag;
	endproperty
	a_calibration_failed_flag_w1c: assert property (p_calibration_failed_flag_w1c) else $error("fail flag not cleared");

	property p_cal_done;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cal_end |=> !cal_busy && calp[4] == $past(cal_i.plus[4]);
	endproperty
	a_cal_done: assert property (p_cal_done) else $error("calibration finish wrong");

	property p_sat_low;
		@(posedge mclk_i) disable iff (!arst_n_i)
		store && diff < 0 |=> result == 12'h000;
	endproperty
	a_sat_low: assert property (p_sat_low) else $error("negative not saturated");

	property p_hw_start;
		@(posedge mclk_i) disable iff (!arst_n_i)
		hw_trig_i && trg_sel && !cal_busy && !cal_go |-> conv_start_o;
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("hardware trigger ignored");

	property p_restart;
		@(posedge mclk_i) disable iff (!arst_n_i)
		conv_end && cont && !cal_busy && !cal_go |-> conv_start_o;
	endproperty
	a_restart: assert property (p_restart) else $error("continuous mode did not restart");

	property p_cmp_drop;
		@(posedge mclk_i) disable iff (!arst_n_i)
		conv_end && cmp_en && cmp_ge && corr < cv_full |=> !conv_complete_o;
	endproperty
	a_cmp_drop: assert property (p_cmp_drop) else $error("failed compare stored");

	// minus value 0 is six bits wide, so only the low six bits may land
	property p_cal_load_m;
		@(posedge mclk_i) disable iff (!arst_n_i)
		cal_end |=> calm[0] == ($past(cal_i.minus[0]) & 10'h03F);
	endproperty
	a_cal_load_m: assert property (p_cal_load_m) else $error("minus value 0 not loaded");

	c_locked_drop: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
		lock && conv_end && !is_8bit);
	c_cal_ok: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
		cal_end && !calibration_failed_flag);
	c_cont: cover property (@(posedge mclk_i) disable iff (!arst_n_i) restart);
	c_hw_trig: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
		hw_start && !cal_busy);
endmodule
`default_nettype wire

// [pkg/arc_pkg.sv]
// arc_pkg: register map, field positions, reset values and carrier types
// for the converter result, compare and calibration register block.
// assumes an 8-bit register port with byte-wide offsets.
`default_nettype none
package arc_pkg;
	// register offsets
	localparam logic [7:0] OFS_RES_HI  = 8'h00;
	localparam logic [7:0] OFS_RES_LO  = 8'h01;
	localparam logic [7:0] OFS_CV_HI   = 8'h02;
	localparam logic [7:0] OFS_CV_LO   = 8'h03;
	localparam logic [7:0] OFS_TRGCMP  = 8'h04;
	localparam logic [7:0] OFS_CALCONT = 8'h05;
	localparam logic [7:0] OFS_OFSC_HI = 8'h06;
	localparam logic [7:0] OFS_OFSC_LO = 8'h07;
	localparam logic [7:0] OFS_PG_HI   = 8'h08;
	localparam logic [7:0] OFS_PG_LO   = 8'h09;
	localparam logic [7:0] OFS_MG_HI   = 8'h0A;
	localparam logic [7:0] OFS_MG_LO   = 8'h0B;
	localparam logic [7:0] OFS_CALP0   = 8'h0C;
	localparam logic [7:0] OFS_CALM0   = 8'h13;
	localparam int         NUM_CAL     = 7;
	// field positions
	localparam int BIT_ACTIVE  = 7;
	localparam int BIT_TRGSEL  = 6;
	localparam int BIT_CMPEN   = 5;
	localparam int BIT_CMPGE   = 4;
	localparam int BIT_CAL     = 7;
	localparam int BIT_CALIBRATION_FAILED_FLAG    = 6;
	localparam int BIT_CONT    = 3;
	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_GAIN = 16'h8000;
	// resolution encodings
	typedef enum logic [1:0] {
		RES_8   = 2'b00,
		RES_12  = 2'b01,
		RES_10  = 2'b10,
		RES_RSV = 2'b11
	} arc_res_t;
	// one finished raw conversion from the analog core
	typedef struct packed {
		logic        done;
		logic [11:0] raw;
	} arc_conv_t;
	// calibration completion with both value sets, each right justified
	typedef struct packed {
		logic                done;
		logic [6:0][9:0]     plus;
		logic [6:0][9:0]     minus;
	} arc_cal_t;
endpackage
`default_nettype wire

// [test/tb_top.sv]
// tb_top: self-checking bench for the result, compare and calibration
// register block; it plays software on the register port and the core.
// assumes arc_pkg and arc_regs are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import arc_pkg::*;
;
	// stimulus and observed signals
	logic        mclk_i      = 1'b0;
	logic        arst_n_i    = 1'b0;
	logic [7:0]  reg_addr_i  = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	arc_res_t    mode_i      = RES_12;
	logic [2:0]  pulse_v     = 3'b000; // stop, hw trigger, sc1 write
	arc_conv_t   conv_i      = '0;
	arc_cal_t    cal_i       = '0;
	logic [7:0]  reg_rdata_o;
	logic        conv_start_o, conv_abort_o, cal_start_o, conv_complete_o;
	logic [15:0] plus_gain_o, minus_gain_o;
	logic        seen_start, seen_abort, seen_cal;
	int          bad_count, num_checks, cycles;
	int          wtab [7] = '{6, 7, 8, 9, 10, 6, 6};

	arc_regs #(.AW(8)) arc_regs_inst (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .mode_i(mode_i), .sc1_wr_i(pulse_v[0]),
		.hw_trig_i(pulse_v[1]), .stop_i(pulse_v[2]), .conv_i(conv_i), .cal_i(cal_i),
		.conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
		.cal_start_o(cal_start_o), .conv_complete_o(conv_complete_o),
		.plus_gain_o(plus_gain_o), .minus_gain_o(minus_gain_o)
	);

	// clock and hang guard; the run needs well under a thousand cycles
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// combinational pulses are caught mid-cycle, while the strobe stands
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(negedge mclk_i);
		seen_abort = conv_abort_o;
		seen_cal = cal_start_o;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		chk(reg_rdata_o, e);
	endtask

	task automatic res(input logic [7:0] h, input logic [7:0] l);
		rd(OFS_RES_HI, h);
		rd(OFS_RES_LO, l);
	endtask

	task automatic kick(input logic [2:0] v);
		@(posedge mclk_i);
		pulse_v <= v;
		@(negedge mclk_i);
		seen_start = conv_start_o;
		@(posedge mclk_i);
		pulse_v <= 3'b000;
	endtask

	// resolution changes on a rising edge like every other input
	task automatic set_mode(input arc_res_t m);
		@(posedge mclk_i);
		mode_i <= m;
	endtask

	// core reports a finished conversion; seen_start keeps the restart pulse
	task automatic fin(input logic [11:0] raw, input logic ec);
		@(posedge mclk_i);
		conv_i <= '{1'b1, raw};
		@(negedge mclk_i);
		seen_start = conv_start_o;
		@(posedge mclk_i);
		conv_i <= '{1'b0, raw};
		@(negedge mclk_i);
		chk(conv_complete_o, ec);
	endtask

	task automatic conv(input logic [11:0] raw, input logic ec);
		kick(3'b001);
		chk(seen_start, 1'b1);
		fin(raw, ec);
	endtask

	task automatic cal_done();
		@(posedge mclk_i);
		cal_i.done <= 1'b1;
		@(posedge mclk_i);
		cal_i.done <= 1'b0;
	endtask

	function automatic logic [7:0] mk(input logic [9:0] v, input int w);
		return 8'(v & ((10'h001 << w) - 10'h001));
	endfunction

	// main sequence
	initial begin
		for (int i = 0; i < NUM_CAL; i++) begin
			cal_i.plus[i] = 10'h3FF;
			cal_i.minus[i] = 10'h155;
		end
		repeat (4) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		for (int a = 0; a < 26; a++) begin
			rd(a[7:0], (a == OFS_PG_HI || a == OFS_MG_HI) ? 8'h80 : 8'h00);
		end
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		chk(plus_gain_o, 16'h8000);
		$display("test reset finished");
		wr(OFS_PG_HI, 8'h12);
		wr(OFS_PG_LO, 8'h34);
		wr(OFS_MG_HI, 8'h56);
		wr(OFS_MG_LO, 8'h78);
		rd(OFS_PG_LO, 8'h34);
		chk(plus_gain_o, 16'h1234);
		chk(minus_gain_o, 16'h5678);
		$display("test gain finished");
		conv(12'h123, 1'b1);
		chk(seen_start, 1'b0);
		rd(OFS_RES_HI, 8'h01);
		conv(12'h456, 1'b0);
		rd(OFS_RES_LO, 8'h23);
		conv(12'h789, 1'b1);
		res(8'h07, 8'h89);
		set_mode(RES_8);
		conv(12'h0AB, 1'b1);
		rd(OFS_RES_HI, 8'h00);
		conv(12'h0CD, 1'b1);
		rd(OFS_RES_LO, 8'hCD);
		$display("test interlock finished");
		// offset is left justified: 0x0100 removes 0x10 counts at 12 bits
		set_mode(RES_12);
		wr(OFS_OFSC_HI, 8'h01);
		conv(12'h105, 1'b1);
		res(8'h00, 8'hF5);
		conv(12'h005, 1'b1);
		res(8'h00, 8'h00);
		wr(OFS_OFSC_HI, 8'hFF);
		conv(12'hFFA, 1'b1);
		res(8'h0F, 8'hFF);
		set_mode(RES_10);
		conv(12'h3FE, 1'b1);
		res(8'h03, 8'hFF);
		wr(OFS_OFSC_HI, 8'h00);
		$display("test offset finished");
		set_mode(RES_12);
		wr(OFS_CV_HI, 8'h01);
		wr(OFS_TRGCMP, 8'h30);
		conv(12'h0FF, 1'b0);
		conv(12'h100, 1'b1);
		wr(OFS_TRGCMP, 8'h20);
		conv(12'h100, 1'b0);
		conv(12'h0FF, 1'b1);
		set_mode(RES_8);
		wr(OFS_TRGCMP, 8'h30);
		wr(OFS_CV_LO, 8'h10);
		conv(12'h010, 1'b1);
		conv(12'h00F, 1'b0);
		set_mode(RES_12);
		$display("test compare finished");
		wr(OFS_TRGCMP, 8'h40);
		kick(3'b010);
		chk(seen_start, 1'b1);
		kick(3'b001);
		chk(seen_start, 1'b0);
		rd(OFS_TRGCMP, 8'hC0);
		fin(12'h0AA, 1'b1);
		rd(OFS_TRGCMP, 8'h40);
		wr(OFS_TRGCMP, 8'h00);
		// the reserved resolution code behaves as 12-bit
		set_mode(RES_RSV);
		conv(12'hABC, 1'b1);
		res(8'h0A, 8'hBC);
		set_mode(RES_12);
		wr(OFS_CALCONT, 8'h08);
		conv(12'h123, 1'b1);
		chk(seen_start, 1'b1);
		rd(OFS_TRGCMP, 8'h80);
		wr(OFS_CALCONT, 8'h00);
		fin(12'h321, 1'b1);
		rd(OFS_TRGCMP, 8'h00);
		$display("test trigger finished");
		// pass 0 is clean and aborts a conversion; the others spoil the run
		// pass 4 keeps the hardware trigger selected, which fails at once
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CALCONT, 8'h40);
			if (k == 0) begin
				kick(3'b001);
			end
			if (k == 4) begin
				wr(OFS_TRGCMP, 8'h40);
			end
			wr(OFS_CALCONT, 8'h80);
			chk(seen_abort, k == 0);
			chk(seen_cal, 1'b1);
			rd(OFS_CALCONT, (k == 4) ? 8'hC0 : 8'h80);
			rd(OFS_TRGCMP, (k == 4) ? 8'h40 : 8'h00);
			case (k)
				1: wr(OFS_CV_LO, 8'h00);
				2: kick(3'b100);
				3: kick(3'b001);
				default: ;
			endcase
			cal_done();
			rd(OFS_CALCONT, (k == 0) ? 8'h00 : 8'h40);
		end
		wr(OFS_CALCONT, 8'h00);
		rd(OFS_CALCONT, 8'h40);
		wr(OFS_CALCONT, 8'h40);
		rd(OFS_CALCONT, 8'h00);
		for (int i = 0; i < NUM_CAL; i++) begin
			rd(OFS_CALP0 + 8'(i), mk(10'h3FF, wtab[i]));
			rd(OFS_CALM0 + 8'(i), mk(10'h155, wtab[i]));
		end
		$display("test calibration finished");
		conclude();
	end
endmodule
`default_nettype wire
